//--- common/acs_pkg.sv
package acs_pkg;
  // register offsets on the plain register port
  localparam logic [7:0] CSR_OFS = 8'h70;
  localparam logic [7:0] RES_HIGH_OFS = 8'h71;
  localparam logic [7:0] RES_LOW_OFS = 8'h72;
  // control and status field positions
  localparam int EOC_BIT = 7;
  localparam int SPEED_BIT = 6;
  localparam int ON_BIT = 5;
  localparam int CH_LSB = 0;
  localparam int CH_W = 4;
  // reset values
  localparam logic [7:0] CSR_RST = 8'h00;
  localparam logic [7:0] RES_RST = 8'h00;
  // converter geometry and timing in converter clock ticks
  localparam int RES_W = 10;
  localparam int SAMPLE_TICKS = 3;
  localparam int SETTLE_TICKS = 2;
  // core clock dividers for the converter clock, minus one
  localparam logic [1:0] DIV_SLOW_M1 = 2'h3;
  localparam logic [1:0] DIV_FAST_M1 = 2'h1;
  // sequencer states
  typedef enum logic [2:0] {
    ACS_OFF = 3'b001,
    ACS_SAMPLE = 3'b010,
    ACS_CONV = 3'b100
  } acs_state_t;
endpackage : acs_pkg

//--- logic/acs_sar_core.sv
`timescale 1ns/1ps
`default_nettype none
module acs_sar_core #(
  parameter int RES_W = acs_pkg::RES_W
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic start,
  input wire logic step,
  input wire logic cmp_high,
  output logic [RES_W-1:0] trial_code,
  output logic done,
  output logic [RES_W-1:0] result
);
  logic [RES_W-1:0] code_reg;
  logic [RES_W-1:0] code_next;
  logic [RES_W-1:0] bit_reg;
  logic [RES_W-1:0] bit_next;
  logic [RES_W-1:0] kept;
  logic last_bit;

  // keep the trial bit when the input sits at or above the trial level;
  // a fixed bit order makes the code monotonic in the input
  assign kept = cmp_high ? code_reg : (code_reg & ~bit_reg);
  assign last_bit = bit_reg[0];
  assign code_next = start ? {1'b1, {(RES_W-1){1'b0}}} :
                     (step ? (kept | (bit_reg >> 1)) : code_reg);
  assign bit_next = start ? {1'b1, {(RES_W-1){1'b0}}} :
                    (step ? (bit_reg >> 1) : bit_reg);
  assign trial_code = code_reg;
  assign result = kept;
  assign done = step & last_bit & ~start;

  // approximation register, one bit decided per step
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      code_reg <= '0;
      bit_reg <= '0;
    end else if (clk_en) begin
      code_reg <= code_next;
      bit_reg <= bit_next;
    end
  end
endmodule : acs_sar_core
`default_nettype wire

//--- logic/acs_sequencer.sv
// Operation
// - hold ten-bit result for software reads
// - select one of sixteen inputs
// - above upper reference gives all ones
// - below lower reference gives zero
// - result code is monotonic in input
// - on bit starts continuous conversions
// - each conversion sets done flag, loads result
// - reading high result clears done flag
// - channel change aborts, clears flag, restarts
// - clearing on bit stops converter
// - wait mode leaves converter running
// - halt disables converter; software waits stabilisation
// - analog pins stay readable as logic
// - control register write clears flag, unless a conversion completes in that cycle
// - high result holds bits nine to two
// - low result holds bits one, zero
// - channel code n routes input n
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer #(
  parameter int RES_W = acs_pkg::RES_W,
  parameter int PINS = 16
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic halt_mode,
  input wire logic cmp_async,
  output logic [3:0] analog_chan_sel,
  output logic [RES_W-1:0] dac_code,
  output logic sample_hold,
  output logic converter_power,
  input wire logic [PINS-1:0] pin_async,
  output logic [PINS-1:0] pin_level
);
  acs_pkg::acs_state_t state_reg;
  acs_pkg::acs_state_t state_next;
  logic converter_on_reg;
  logic speed_reg;
  logic [3:0] channel_select_reg;
  logic eoc_reg;
  logic eoc_next;
  logic [7:0] result_high_reg;
  logic [7:0] result_low_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [1:0] div_reg;
  logic [3:0] tick_cnt_reg;
  logic [3:0] tick_cnt_next;
  logic cmp_meta_reg;
  logic cmp_sync_reg;
  logic [PINS-1:0] pin_meta_reg;
  logic [PINS-1:0] pin_sync_reg;

  // all checks below run on the core clock and sleep through reset
  default clocking acs_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  wire sel_csr = (reg_addr == acs_pkg::CSR_OFS);
  wire sel_high = (reg_addr == acs_pkg::RES_HIGH_OFS);
  wire sel_low = (reg_addr == acs_pkg::RES_LOW_OFS);
  wire csr_wr = clk_en & reg_wr & sel_csr;
  wire high_rd = clk_en & reg_rd & sel_high;
  wire [3:0] new_chan = reg_wdata[acs_pkg::CH_LSB +: acs_pkg::CH_W];
  wire chan_change = csr_wr & (new_chan != channel_select_reg);
  // wait mode is not an input at all: only halt gates the converter
  wire converter_active = converter_on_reg & ~halt_mode;
  wire [1:0] div_limit = speed_reg ? acs_pkg::DIV_FAST_M1 : acs_pkg::DIV_SLOW_M1;
  wire adc_tick = (div_reg == div_limit);

  wire core_start;
  wire core_step;
  wire core_done;
  wire [RES_W-1:0] core_result;
  wire [RES_W-1:0] core_trial;
  wire conv_done = core_done & converter_active & ~chan_change;

  // tick counting is shared by the sample and bit settle phases
  function automatic logic [3:0] ticks_left(input logic [3:0] cnt, input logic tick);
    ticks_left = (tick && cnt != 4'h0) ? cnt - 4'h1 : cnt;
  endfunction : ticks_left

  // comparator and port pins come from outside the clock domain
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmp_meta_reg <= 1'b0;
      cmp_sync_reg <= 1'b0;
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else if (clk_en) begin
      cmp_meta_reg <= cmp_async;
      cmp_sync_reg <= cmp_meta_reg;
      pin_meta_reg <= pin_async;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // analog pins keep their logic read path
  assign pin_level = pin_sync_reg;

  // converter clock prescaler, restarted while stopped
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= 2'h0;
    end else if (clk_en) begin
      div_reg <= (!converter_active || adc_tick) ? 2'h0 : div_reg + 2'h1;
    end
  end

  // sequencer: sample, then one settle window per result bit
  always_comb begin
    state_next = state_reg;
    tick_cnt_next = ticks_left(tick_cnt_reg, adc_tick);
    unique case (state_reg)
      acs_pkg::ACS_OFF: begin
        if (converter_active) begin
          state_next = acs_pkg::ACS_SAMPLE;
          tick_cnt_next = 4'(acs_pkg::SAMPLE_TICKS);
        end
      end
      acs_pkg::ACS_SAMPLE: begin
        if (adc_tick && tick_cnt_reg == 4'h1) begin
          state_next = acs_pkg::ACS_CONV;
          tick_cnt_next = 4'(acs_pkg::SETTLE_TICKS);
        end
      end
      acs_pkg::ACS_CONV: begin
        if (core_step) begin
          // the next sample starts right away, no command needed
          state_next = core_done ? acs_pkg::ACS_SAMPLE : acs_pkg::ACS_CONV;
          tick_cnt_next = core_done ? 4'(acs_pkg::SAMPLE_TICKS) :
                          4'(acs_pkg::SETTLE_TICKS);
        end
      end
    endcase
    if (chan_change && converter_active) begin
      state_next = acs_pkg::ACS_SAMPLE;
      tick_cnt_next = 4'(acs_pkg::SAMPLE_TICKS);
    end
    if (!converter_active) begin
      state_next = acs_pkg::ACS_OFF;
      tick_cnt_next = 4'h0;
    end
  end

  assign core_start = (state_reg == acs_pkg::ACS_SAMPLE);
  assign core_step = (state_reg == acs_pkg::ACS_CONV) & adc_tick & (tick_cnt_reg == 4'h1);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= acs_pkg::ACS_OFF;
      tick_cnt_reg <= 4'h0;
    end else if (clk_en) begin
      state_reg <= state_next;
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  // successive approximation; saturation and zero fall out of the search
  acs_sar_core #(
    .RES_W(RES_W)
  ) u_sar (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .start(core_start),
    .step(core_step),
    .cmp_high(cmp_sync_reg),
    .trial_code(core_trial),
    .done(core_done),
    .result(core_result)
  );

  // analog side outputs
  assign analog_chan_sel = channel_select_reg;
  assign dac_code = core_trial;
  assign sample_hold = (state_reg == acs_pkg::ACS_SAMPLE);
  assign converter_power = converter_active;

  // done flag: a completing conversion wins over a clearing access,
  // except a channel change, which aborts that conversion
  assign eoc_next = conv_done ? 1'b1 :
                    ((high_rd || csr_wr) ? 1'b0 : eoc_reg);

  // control fields; done flag is read only
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      converter_on_reg <= acs_pkg::CSR_RST[acs_pkg::ON_BIT];
      speed_reg <= acs_pkg::CSR_RST[acs_pkg::SPEED_BIT];
      channel_select_reg <= acs_pkg::CSR_RST[acs_pkg::CH_LSB +: acs_pkg::CH_W];
      eoc_reg <= acs_pkg::CSR_RST[acs_pkg::EOC_BIT];
    end else if (clk_en) begin
      eoc_reg <= eoc_next;
      if (csr_wr) begin
        converter_on_reg <= reg_wdata[acs_pkg::ON_BIT];
        speed_reg <= reg_wdata[acs_pkg::SPEED_BIT];
        channel_select_reg <= new_chan;
      end
    end
  end

  // results are not latched against reads: software must be quick
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      result_high_reg <= acs_pkg::RES_RST;
      result_low_reg <= acs_pkg::RES_RST;
    end else if (clk_en && conv_done) begin
      result_high_reg <= core_result[RES_W-1:RES_W-8];
      result_low_reg <= {6'h00, core_result[1:0]};
    end
  end

  // read mux; reserved bit four and unmapped addresses read zero
  assign rdata_next = !reg_rd ? 8'h00 :
                      sel_csr ? {eoc_reg, speed_reg, converter_on_reg, 1'b0,
                                 channel_select_reg} :
                      sel_high ? result_high_reg :
                      sel_low ? result_low_reg : 8'h00;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 8'h00;
    end else if (clk_en) begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  sequence seq_done_edge;
    clk_en && conv_done;
  endsequence

  sequence seq_clear_access;
    clk_en && !conv_done && (high_rd || csr_wr);
  endsequence

  sequence seq_switch_on;
    clk_en && state_reg == acs_pkg::ACS_OFF && converter_active;
  endsequence

  done_sets_flag_a: assert property (seq_done_edge |=> eoc_reg)
    else $error("done flag not set after conversion");

  result_high_load_a: assert property (seq_done_edge |=>
      result_high_reg == $past(core_result[9:2]))
    else $error("high result not loaded");

  result_low_load_a: assert property (seq_done_edge |=>
      result_low_reg == {6'h00, $past(core_result[1:0])})
    else $error("low result not loaded");

  access_clears_flag_a: assert property (seq_clear_access |=> !eoc_reg)
    else $error("done flag survived a clearing access");

  chan_restart_a: assert property (clk_en && chan_change && converter_active |=>
      state_reg == acs_pkg::ACS_SAMPLE && !eoc_reg)
    else $error("channel change did not restart");

  // power may come back at the very edge that switches on, so only the state and the step strobe are checked late
  off_stops_a: assert property (clk_en && !converter_active |=>
      state_reg == acs_pkg::ACS_OFF && !core_step)
    else $error("converter kept running while off");

  halt_power_a: assert property (halt_mode || !converter_on_reg |-> !converter_power)
    else $error("converter powered while halted or off");

  start_conv_a: assert property (seq_switch_on ##1 (clk_en && converter_active &&
      !chan_change) |=> state_reg == acs_pkg::ACS_SAMPLE)
    else $error("conversion did not start");

  overrun_flag_a: assert property (clk_en && eoc_reg && conv_done |=>
      eoc_reg && result_high_reg == $past(core_result[9:2]))
    else $error("overrun lost flag or result");

  read_data_a: assert property (clk_en && reg_rd && sel_high |=>
      reg_rdata == $past(result_high_reg))
    else $error("high result read wrong");
endmodule : acs_sequencer
`default_nettype wire

//--- testbench/acs_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module acs_analog_model (
  input wire logic [3:0] analog_chan_sel,
  input wire logic [9:0] dac_code,
  input wire logic converter_power,
  output logic cmp_async
);
  // one level per analog input, set by the bench
  logic [9:0] input_voltage [16];
  logic flip = 1'b0;

  // unpowered comparator toggles so a stale level never looks valid
  always #3.3 flip = ~flip;

  // comparator: high when input at or above trial code, monotonic in input
  assign cmp_async = converter_power ? (input_voltage[analog_chan_sel] >= dac_code) : flip;
endmodule : acs_analog_model
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic halt_mode = 1'b0;
  logic clk_en = 1'b1;
  logic [15:0] pin_async = 16'h0000;
  logic [7:0] reg_rdata;
  logic [3:0] analog_chan_sel;
  logic [9:0] dac_code;
  logic cmp_async;
  logic sample_hold;
  logic converter_power;
  logic [15:0] pin_level;
  logic chk_now = 1'b0;
  logic look = 1'b0;
  logic [7:0] exp_q [$];
  logic [7:0] got = 8'h00;
  logic [7:0] e;
  logic [9:0] lvl;
  logic [3:0] chans [4] = '{4'h3, 4'h5, 4'hc, 4'hf};
  int error_cnt = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  int seed = 32'h7192;

  always #2.5 sys_clk = ~sys_clk;

  acs_sequencer u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .halt_mode(halt_mode), .cmp_async(cmp_async), .analog_chan_sel(analog_chan_sel),
    .dac_code(dac_code), .sample_hold(sample_hold), .converter_power(converter_power),
    .pin_async(pin_async), .pin_level(pin_level)
  );

  acs_analog_model u_model (
    .analog_chan_sel(analog_chan_sel), .dac_code(dac_code),
    .converter_power(converter_power), .cmp_async(cmp_async)
  );

  task cmp(input logic [7:0] g, input logic [7:0] x, input string m);
    tests_run++;
    if (g !== x) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, g, x);
    end
  endtask : cmp

  task give_verdict;
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // expected value noted in the queue at the strobe, compared by the watcher
  task rd(input logic [7:0] a, input logic [7:0] x, input logic c);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    chk_now <= c;
    if (c) exp_q.push_back(x);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
  endtask : rd

  // bounded poll of the done flag
  task poll;
    n = 0;
    got = 8'h00;
    while (got[7] !== 1'b1 && n < 100) begin
      rd(8'h70, 8'h00, 1'b0);
      n++;
    end
    if (got[7] !== 1'b1) cmp(got, 8'h80, "done flag never set");
  endtask : poll

  // read data stands one cycle after the strobe: look mid-cycle
  always @(posedge sys_clk) look <= reg_rd & chk_now;
  always @(negedge sys_clk) begin
    if (look) begin
      e = exp_q.pop_front();
      cmp(reg_rdata, e, "read data");
    end
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("mismatch at %0t: run did not finish", $time);
      give_verdict();
    end
  end

  initial begin
    for (int i = 0; i < 16; i++) u_model.input_voltage[i] = 10'($random(seed));
    u_model.input_voltage[5] = 10'h3ff;
    u_model.input_voltage[12] = 10'h000;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(8'h70, 8'h00, 1'b1);
    rd(8'h71, 8'h00, 1'b1);
    rd(8'h72, 8'h00, 1'b1);
    rd(8'h73, 8'h00, 1'b1);
    wr(8'h71, 8'hff);
    rd(8'h71, 8'h00, 1'b1);
    $display("reset and map test done");
    // odd passes run the fast converter clock, even passes the slow one
    foreach (chans[k]) begin
      lvl = u_model.input_voltage[chans[k]];
      wr(8'h70, {1'b0, k[0], 2'h2, chans[k]});
      rd(8'h70, {1'b0, k[0], 2'h2, chans[k]}, 1'b1);
      poll();
      rd(8'h72, {6'h00, lvl[1:0]}, 1'b1);
      rd(8'h71, lvl[9:2], 1'b1);
      rd(8'h70, {1'b0, k[0], 2'h2, chans[k]}, 1'b1);
      poll();
      $display("channel %0d test done", chans[k]);
    end
    repeat (100) @(posedge sys_clk);
    rd(8'h70, 8'hef, 1'b1);
    rd(8'h71, lvl[9:2], 1'b1);
    poll();
    wr(8'h70, 8'h6f);
    rd(8'h70, 8'h6f, 1'b1);
    $display("overrun and flag test done");
    @(posedge sys_clk);
    halt_mode <= 1'b1;
    @(posedge sys_clk);
    #1 cmp({7'h00, converter_power}, 8'h00, "halt power");
    @(posedge sys_clk);
    halt_mode <= 1'b0;
    @(posedge sys_clk);
    #1 cmp({7'h00, converter_power}, 8'h01, "power after halt");
    wr(8'h70, 8'h4f);
    #1 cmp({7'h00, converter_power}, 8'h00, "off power");
    @(posedge sys_clk);
    #1 cmp({7'h00, sample_hold}, 8'h00, "sampling after off");
    $display("power test done");
    // with the clock enable low the synchronisers must hold their old level
    @(posedge sys_clk);
    clk_en <= 1'b0;
    pin_async <= 16'($random(seed));
    repeat (3) @(posedge sys_clk);
    #1 cmp(pin_level[7:0], 8'h00, "pins moved while frozen");
    @(posedge sys_clk);
    clk_en <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 cmp(pin_level[7:0], pin_async[7:0], "pin low");
    cmp(pin_level[15:8], pin_async[15:8], "pin high");
    $display("pin test done");
    repeat (4) @(posedge sys_clk);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
